/* irq_test_pkg.sv */
// shared constants, types and register layout of the interrupt test override block
package irq_test_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] CTL_IDX      = 8'h15;
  localparam logic [7:0] TEST_IDX     = 8'h16;
  localparam logic [7:0] CTL_ADDR     = 8'h54;
  localparam logic [7:0] TEST_ADDR    = 8'h58;

  // control register fields
  localparam int         CTL_OVR_BIT  = 4;
  localparam int         CTL_SEL_LSB  = 0;
  localparam int         SEL_W        = 4;
  localparam int         GROUP_W      = 8;

  // reset values
  localparam logic [7:0] TEST_RESET   = 8'h00;
  localparam logic [3:0] SEL_RESET    = 4'h0;
  localparam logic       OVR_RESET    = 1'b0;

  // documented group count: one group per select value
  localparam int         GROUPS_DOC   = 16;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_BUSY = 2'b01,
    S_ACK  = 2'b10
  } bus_state_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } avs_req_t;

  typedef struct packed {
    logic        override_enable;
    logic [3:0]  select;
  } test_ctl_t;

  typedef struct packed {
    logic special_mode;
    logic i_mask;
    logic x_mask;
  } cpu_mode_t;

endpackage

/* irq_test_bank.sv */
// storage of the software-written interrupt test values, one byte per group
module irq_test_bank
  import irq_test_pkg::*;
#(
  parameter int GROUPS = GROUPS_DOC
) (
  input  wire logic                        clk_sys,
  input  wire logic                        reset_n,
  input  wire logic                        wr_en,
  input  wire logic [SEL_W-1:0]            wr_idx,
  input  wire logic [GROUP_W-1:0]          wr_data,
  input  wire logic                        load_en,
  input  wire logic [GROUPS*GROUP_W-1:0]   load_data,
  input  wire logic [SEL_W-1:0]            rd_idx,
  output logic      [GROUP_W-1:0]          rd_data,
  output logic      [GROUPS*GROUP_W-1:0]   all_words
);

  if (GROUPS < 1 || GROUPS > GROUPS_DOC) begin : g_bad_groups
    $error("GROUPS must lie between 1 and 16");
  end

  typedef struct packed {
    logic [GROUPS-1:0][GROUP_W-1:0] words;
    logic [GROUP_W-1:0]             rd;
  } bank_t;

  bank_t bank_q;
  bank_t bank_d;

  always_comb begin
    bank_d = bank_q;
    // whole-bank load keeps every request pending at the moment override starts
    if (load_en) begin
      bank_d.words = load_data;
    end
    for (int g = 0; g < GROUPS; g++) begin
      if (wr_en && (32'(wr_idx) == g)) begin
        bank_d.words[g] = wr_data;
      end
    end
    bank_d.rd = (32'(rd_idx) < GROUPS) ? bank_q.words[rd_idx] : TEST_RESET;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bank_q <= '0;
    end else begin
      bank_q <= bank_d;
    end
  end

  assign rd_data   = bank_q.rd;
  assign all_words = bank_q.words;

endmodule

/* irq_test_override.sv */
// interrupt request test override: avalon register slave and request path mux
// What this block does
// - override off: test writes ignored, special reads live
// - override on: decoder sees test values instead
// - override bit writable only special, I, X
// - pending requests kept when override starts
// - select nibble picks group of eight vectors
// - select field readable and writable any time
// - special read: live inputs or written values
// - normal mode test reads return zero
// - test write needs special, override, I mask
module irq_test_override
  import irq_test_pkg::*;
#(
  parameter int GROUPS = GROUPS_DOC
) (
  input  wire logic                        clk_sys,
  input  wire logic                        reset_n,
  input  wire avs_req_t                    avs_req,
  output logic                             avs_waitrequest,
  output logic      [31:0]                 avs_readdata,
  input  wire cpu_mode_t                   cpu_mode,
  input  wire logic [GROUPS*GROUP_W-1:0]   irq_in,
  output logic      [GROUPS*GROUP_W-1:0]   irq_to_decoder
);

  ////////////////////////////////////////////////////////////////////////////
  // parameter check

  if (GROUPS < 1 || GROUPS > GROUPS_DOC) begin : g_bad_groups
    $error("GROUPS must lie between 1 and 16");
  end

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    bus_state_t                  st;
    logic                        waitreq;
    logic [31:0]                 rdata;
    test_ctl_t                   ctl;
    logic [GROUPS*GROUP_W-1:0]   irq;
  } core_t;

  core_t                       q;
  core_t                       d;
  logic                        bank_we;
  logic                        bank_load;
  logic [GROUP_W-1:0]          bank_rd;
  logic [GROUPS*GROUP_W-1:0]   bank_all;
  logic [GROUP_W-1:0]          live_byte;
  logic                        sel_ok;
  logic                        ovr_allowed;
  logic                        test_wr_allowed;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_addr);
    return addr == reg_addr;
  endfunction

  function automatic logic [31:0] ctl_word(input test_ctl_t c);
    logic [31:0] w;
    w = '0;
    w[CTL_OVR_BIT] = c.override_enable;
    w[CTL_SEL_LSB +: SEL_W] = c.select;
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // test value storage

  irq_test_bank #(
    .GROUPS (GROUPS)
  ) u_bank (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .wr_en     (bank_we),
    .wr_idx    (q.ctl.select),
    .wr_data   (avs_req.writedata[GROUP_W-1:0]),
    .load_en   (bank_load),
    .load_data (irq_in),
    .rd_idx    (q.ctl.select),
    .rd_data   (bank_rd),
    .all_words (bank_all)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  assign sel_ok          = 32'(q.ctl.select) < GROUPS;
  // bit k of a group is the source whose vector low nibble is 2k
  assign live_byte       = sel_ok ? irq_in[{q.ctl.select, 3'b000} +: GROUP_W] : TEST_RESET;
  assign ovr_allowed     = cpu_mode.special_mode && cpu_mode.i_mask && cpu_mode.x_mask;
  assign test_wr_allowed = cpu_mode.special_mode && q.ctl.override_enable && cpu_mode.i_mask && sel_ok;

  always_comb begin
    d         = q;
    bank_we   = 1'b0;
    bank_load = 1'b0;
    unique case (q.st)
      S_IDLE: begin
        if (avs_req.read || avs_req.write) begin
          d.st = S_BUSY;
        end
      end
      S_BUSY: begin
        // one wait cycle so the bank's registered read data are ready
        d.st      = S_ACK;
        d.waitreq = 1'b0;
        d.rdata   = '0;
        if (avs_req.read && hit(avs_req.address, CTL_ADDR)) begin
          d.rdata = ctl_word(q.ctl);
        end else if (avs_req.read && hit(avs_req.address, TEST_ADDR) && cpu_mode.special_mode) begin
          d.rdata[GROUP_W-1:0] = q.ctl.override_enable ? bank_rd : live_byte;
        end
        // normal mode test reads and unmapped addresses read as zero
      end
      S_ACK: begin
        // write commits at the edge where the master sees waitrequest low
        d.st      = S_IDLE;
        d.waitreq = 1'b1;
        if (avs_req.write && avs_req.byteenable[0]) begin
          if (hit(avs_req.address, CTL_ADDR)) begin
            d.ctl.select = avs_req.writedata[CTL_SEL_LSB +: SEL_W];
            if (ovr_allowed) begin
              d.ctl.override_enable = avs_req.writedata[CTL_OVR_BIT];
              bank_load = avs_req.writedata[CTL_OVR_BIT] && !q.ctl.override_enable;
            end
          end else if (hit(avs_req.address, TEST_ADDR)) begin
            bank_we = test_wr_allowed;
          end
        end
      end
      default: begin
        d.st      = S_IDLE;
        d.waitreq = 1'b1;
      end
    endcase
    // decoder sees live inputs, or the bank while override is on
    d.irq = q.ctl.override_enable ? bank_all : irq_in;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      q.st                  <= S_IDLE;
      q.waitreq             <= 1'b1;
      q.rdata               <= '0;
      q.ctl.override_enable <= OVR_RESET;
      q.ctl.select          <= SEL_RESET;
      q.irq                 <= '0;
    end else begin
      q <= d;
    end
  end

  assign avs_waitrequest = q.waitreq;
  assign avs_readdata    = q.rdata;
  assign irq_to_decoder  = q.irq;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  logic commit_wr;
  logic ack_rd_test;
  logic ack_rd_ctl;
  logic ack_rd_other;
  assign commit_wr    = (q.st == S_ACK) && avs_req.write && avs_req.byteenable[0];
  assign ack_rd_test  = (q.st == S_ACK) && avs_req.read && hit(avs_req.address, TEST_ADDR);
  assign ack_rd_ctl   = (q.st == S_ACK) && avs_req.read && hit(avs_req.address, CTL_ADDR);
  assign ack_rd_other = (q.st == S_ACK) && avs_req.read
                        && !hit(avs_req.address, TEST_ADDR) && !hit(avs_req.address, CTL_ADDR);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////////////////
  // register bus handshake

  a_bus_answer_time: assert property (
    (avs_req.read || avs_req.write) && (q.st == S_IDLE)
    |-> avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest)
    else $error("waitrequest did not drop two cycles after request");

  // a second low cycle would let a held write commit twice
  a_wait_one_low: assert property (
    !avs_waitrequest
    |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");

  // read data are only reloaded while a transfer is being answered
  a_readdata_hold: assert property (
    q.st != S_BUSY
    |=> $stable(avs_readdata))
    else $error("read data changed outside a read answer");

  a_upper_zero: assert property (
    avs_readdata[31:8] == 24'h000000)
    else $error("upper read data bits not zero");

  a_unmapped_zero: assert property (
    ack_rd_other
    |-> avs_readdata == 32'h00000000)
    else $error("unmapped address did not read zero");

  ////////////////////////////////////////////////////////////////////////////
  // request path to the priority decoder

  a_live_path_off: assert property (
    !q.ctl.override_enable
    |=> irq_to_decoder == $past(irq_in))
    else $error("decoder not fed live inputs with override off");

  a_test_path_on: assert property (
    q.ctl.override_enable
    |=> irq_to_decoder == $past(bank_all))
    else $error("decoder not fed test values with override on");

  // the mux follows the registered bit, so the switch lags the commit by one cycle
  a_switch_lag: assert property (
    $rose(q.ctl.override_enable)
    |-> irq_to_decoder == $past(irq_in))
    else $error("decoder switched in the commit cycle");

  ////////////////////////////////////////////////////////////////////////////
  // control register

  a_override_guard: assert property (
    $changed(q.ctl.override_enable)
    |-> $past(ovr_allowed) && $past(commit_wr) && $past(hit(avs_req.address, CTL_ADDR)))
    else $error("override bit changed without special mode and masks");

  a_override_taken: assert property (
    commit_wr && hit(avs_req.address, CTL_ADDR) && ovr_allowed
    |=> q.ctl.override_enable == $past(avs_req.writedata[CTL_OVR_BIT]))
    else $error("allowed override write lost");

  a_override_refused: assert property (
    commit_wr && hit(avs_req.address, CTL_ADDR) && !ovr_allowed
    |=> $stable(q.ctl.override_enable))
    else $error("override bit taken outside special mode with masks");

  a_select_any: assert property (
    commit_wr && hit(avs_req.address, CTL_ADDR)
    |=> q.ctl.select == $past(avs_req.writedata[3:0]))
    else $error("select field write lost");

  a_ctl_read: assert property (
    ack_rd_ctl
    |-> avs_readdata == {27'h0000000, $past(q.ctl.override_enable), $past(q.ctl.select)})
    else $error("control register read wrong");

  ////////////////////////////////////////////////////////////////////////////
  // test register and bank

  a_pending_kept: assert property (
    $rose(q.ctl.override_enable)
    |-> bank_all == $past(irq_in))
    else $error("pending requests lost when override started");

  a_load_only_on_enable: assert property (
    bank_load
    |-> commit_wr && hit(avs_req.address, CTL_ADDR) && ovr_allowed && !q.ctl.override_enable)
    else $error("bank loaded outside an override switch-on");

  // clearing override leaves the bank; switching back on reloads it from the live inputs
  a_clear_keeps: assert property (
    $fell(q.ctl.override_enable)
    |-> $stable(bank_all))
    else $error("bank changed when override was cleared");

  a_bank_held: assert property (
    !bank_we && !bank_load
    |=> $stable(bank_all))
    else $error("bank changed without a write or a load");

  a_test_write_lands: assert property (
    commit_wr && hit(avs_req.address, TEST_ADDR) && cpu_mode.special_mode && cpu_mode.i_mask
    && q.ctl.override_enable && sel_ok
    |-> bank_we)
    else $error("allowed test write dropped");

  a_write_needs_imask: assert property (
    bank_we
    |-> cpu_mode.special_mode && cpu_mode.i_mask && q.ctl.override_enable)
    else $error("test write taken without special mode, override and I mask");

  a_group_write: assert property (
    bank_we
    |=> bank_all[{$past(q.ctl.select), 3'b000} +: GROUP_W] == $past(avs_req.writedata[7:0]))
    else $error("test write did not reach the selected group");

  // two checks per group: a write must leave every other group untouched, and each live byte must reach its own decoder group
  for (genvar g = 0; g < GROUPS; g++) begin : g_group_check
    a_group_only: assert property (
      bank_we && (32'(q.ctl.select) != g)
      |=> $stable(bank_all[g*GROUP_W +: GROUP_W]))
      else $error("test write reached a group that was not selected");

    a_group_live: assert property (
      !q.ctl.override_enable
      |=> irq_to_decoder[g*GROUP_W +: GROUP_W] == $past(irq_in[g*GROUP_W +: GROUP_W]))
      else $error("live request byte reached the wrong decoder group");
  end

  a_live_read: assert property (
    ack_rd_test && $past(cpu_mode.special_mode) && $past(q.st) == S_BUSY && !q.ctl.override_enable
    |-> avs_readdata == {24'h000000, $past(live_byte)})
    else $error("special mode read did not return live inputs");

  a_live_group_read: assert property (
    ack_rd_test && $past(cpu_mode.special_mode) && !q.ctl.override_enable && $past(sel_ok)
    |-> avs_readdata[7:0] == $past(irq_in[{q.ctl.select, 3'b000} +: GROUP_W]))
    else $error("read did not return the group picked by the select field");

  a_test_read: assert property (
    ack_rd_test && $past(cpu_mode.special_mode) && q.ctl.override_enable
    |-> avs_readdata == {24'h000000, $past(bank_rd)})
    else $error("special mode read did not return written values");

  a_normal_zero: assert property (
    ack_rd_test && !$past(cpu_mode.special_mode)
    |-> avs_readdata == 32'h00000000)
    else $error("normal mode test read not zero");

  a_write_guard: assert property (
    commit_wr && hit(avs_req.address, TEST_ADDR) && !test_wr_allowed
    |=> bank_all == $past(bank_all))
    else $error("test write taken while not allowed");

  a_write_off: assert property (
    commit_wr && hit(avs_req.address, TEST_ADDR) && !q.ctl.override_enable
    |=> $stable(bank_all))
    else $error("test write taken with override off");

  ////////////////////////////////////////////////////////////////////////////
  // coverage of the main scenarios

  c_override_on:   cover property ($rose(q.ctl.override_enable));
  c_test_write:    cover property (bank_we);
  c_live_read:     cover property (ack_rd_test && !q.ctl.override_enable && $past(cpu_mode.special_mode));
  c_test_read:     cover property (ack_rd_test && q.ctl.override_enable && $past(cpu_mode.special_mode));
  c_refused_write: cover property (commit_wr && hit(avs_req.address, TEST_ADDR) && !test_wr_allowed);

endmodule

/* irq_peer.sv */
// partner model: interrupt request sources feeding the block
module irq_peer
  import irq_test_pkg::*;
(
  input  wire logic [7:0]   pattern,
  output logic      [127:0] irq_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // groups differ by their index so a wrong select shows up
  always_comb begin
    for (int g = 0; g < 16; g++) begin
      irq_in[g*GROUP_W +: GROUP_W] = pattern ^ 8'(g);
    end
  end
endmodule

/* test_irq_test_override.sv */
// testbench of the interrupt test override block
module test_irq_test_override
  import irq_test_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys;
  logic        reset_n;
  avs_req_t    req;
  cpu_mode_t   mode;
  logic        avs_waitrequest;
  logic [31:0] avs_readdata;
  logic [7:0]  pattern;
  logic [127:0] irq_in;
  logic [127:0] irq_to_decoder;
  int          mismatches;
  int          checked;

  irq_peer irq_peer_i (.pattern(pattern), .irq_in(irq_in));
  irq_test_override irq_test_override_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .avs_req(req),
    .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
    .cpu_mode(mode), .irq_in(irq_in), .irq_to_decoder(irq_to_decoder));

  ////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one edge passes after release so the next request never lands in the same step
  task automatic bus(input logic rd, input logic [7:0] a, input logic [7:0] wd, output logic [31:0] q);
    int n;
    n = 0;
    req.read <= rd;
    req.write <= !rd;
    req.address <= a;
    req.writedata <= {24'h000000, wd};
    req.byteenable <= 4'hf;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    if (n >= 50) begin
      mismatches++;
      $display("[FAIL] %0t bus answer timed out", $time);
    end
    req.read <= 1'b0;
    req.write <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b0, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] q;
    bus(1'b1, a, 8'h00, q);
    chk(q, {24'h000000, exp});
  endtask

  task automatic dec_chk(input int g, input logic [7:0] exp);
    repeat (2) @(posedge clk_sys);
    chk({24'h000000, irq_to_decoder[g*8 +: 8]}, {24'h000000, exp});
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd_chk(CTL_ADDR, 8'h00);
    rd_chk(TEST_ADDR, 8'h00);
    rd_chk(8'h40, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_normal();
    mode <= 3'b011;
    wr(CTL_ADDR, 8'h13);
    rd_chk(CTL_ADDR, 8'h03);
    wr(TEST_ADDR, 8'hff);
    rd_chk(TEST_ADDR, 8'h00);
    $display("test normal done");
  endtask

  task automatic t_live();
    mode <= 3'b100;
    wr(CTL_ADDR, 8'h15);
    rd_chk(CTL_ADDR, 8'h05);
    rd_chk(TEST_ADDR, 8'h3c ^ 8'h05);
    dec_chk(5, 8'h3c ^ 8'h05);
    $display("test live done");
  endtask

  task automatic t_override();
    mode <= 3'b111;
    wr(CTL_ADDR, 8'h15);
    rd_chk(CTL_ADDR, 8'h15);
    pattern <= 8'hc3;
    rd_chk(TEST_ADDR, 8'h3c ^ 8'h05);
    dec_chk(5, 8'h3c ^ 8'h05);
    wr(TEST_ADDR, 8'ha5);
    rd_chk(TEST_ADDR, 8'ha5);
    dec_chk(5, 8'ha5);
    $display("test override done");
  endtask

  task automatic t_refuse();
    mode <= 3'b101;
    wr(TEST_ADDR, 8'h5a);
    rd_chk(TEST_ADDR, 8'ha5);
    wr(CTL_ADDR, 8'h02);
    rd_chk(CTL_ADDR, 8'h12);
    rd_chk(TEST_ADDR, 8'h3c ^ 8'h02);
    mode <= 3'b011;
    rd_chk(TEST_ADDR, 8'h00);
    mode <= 3'b111;
    wr(CTL_ADDR, 8'h02);
    rd_chk(TEST_ADDR, 8'hc3 ^ 8'h02);
    dec_chk(2, 8'hc3 ^ 8'h02);
    $display("test refuse done");
  endtask

  task automatic end_of_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    req = '0;
    mode = '0;
    pattern = 8'h3c;
    reset_n = 1'b0;
    mismatches = 0;
    checked = 0;
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_normal();
    t_live();
    t_override();
    t_refuse();
    end_of_test();
  end

  // about 100 cycles of traffic; far more means a hung handshake
  initial begin
    repeat (3000) @(posedge clk_sys);
    mismatches++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_of_test();
  end
endmodule
